// file: rtl/msq_top.sv
// microprogram sequencer: next-address select, stack, pipeline, wishbone slave
// Operation
// - nine-bit microaddress reaches all 512 words; wider cascade unused.
// - each microword is 40 bits holding all datapath and sequencer controls.
// - branch words carry target address, load-immediate words carry the constant.
// - memory output captured in pipeline register; next address fetched meanwhile.
// - sixteen-bit constant enters input register on the pipeline-load edge.
// - input from external bus or constant; result to result or secondary bus.
// - select 00 counter, 01 address register, 10 stack, 11 direct field.
// - address register loads result bus low nine bits every clock.
// - direct field is nine microword bits giving the branch target.
// - four-entry return stack; pointer counts up/down, marks last written entry.
// - enable high holds; low with direction high pushes; low otherwise pops.
// - call: direction one, enable zero, microprogram counter pushed, pointer up.
// - return: enable and direction low, stack selected, pointer down next clock.
// - counter adds increment bit; zero makes the instruction that follows run twice.
// - clear from panel switch or host reset zeroes the microprogram counter.
// - branch logic gives select 11 on true condition, 00 on false.
`timescale 1ns/1ps
`include "msq_cfg.svh"
module msq_top (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic [7:0] ADR_I,
    input wire logic [31:0] DAT_I,
    input wire logic WE_I,
    input wire logic [3:0] SEL_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    input wire logic PANEL_CLEAR_I,
    input wire logic HOST_BUS_RESET_I,
    input wire logic [`MSQ_DW-1:0] RESULT_I,
    input wire logic [`MSQ_DW-1:0] D_BUS_I,
    output logic [`MSQ_UW-1:0] MICROWORD_O,
    output logic [`MSQ_DW-1:0] INPUT_REG_O,
    output logic [`MSQ_AW-1:0] MPC_O,
    output logic [`MSQ_DW-1:0] Y_BUS_O,
    output logic Y_BUS_VALID_O,
    output logic [`MSQ_DW-1:0] C_BUS_O,
    output logic C_BUS_VALID_O
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    msq_pkg::msq_state_t q, next_q;
    msq_pkg::msq_src_t src;
    logic [`MSQ_UW-1:0] pipe;
    logic [`MSQ_DW-1:0] inreg;
    logic [`MSQ_AW-1:0] next_addr;
    logic [`MSQ_AW-1:0] dir_plus;
    logic [`MSQ_AW-1:0] res_lo;
    logic [31:0] merged;
    logic clr, seq_go, push, pop, hit, mem_we;
    logic [`MSQ_UW-1:0] mem_wdata;

    function automatic logic [31:0] lane_merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0] sel
    );
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // sequencer decode
    // ------------------------------------------------------------------
    // clear sources; pins go through two flops first
    assign clr = q.pan_s[1] | q.host_s[1] | q.clr_req;
    // branch logic outside drives the select field; 11 taken, 00 not taken
    assign src = msq_pkg::msq_src_t'(pipe[`MSQ_F_SEL_MSB:`MSQ_F_SEL_LSB]);
    assign seq_go = q.run & ~clr;
    assign push = seq_go & ~pipe[`MSQ_F_FEN] & pipe[`MSQ_F_SDIR];
    assign pop = seq_go & ~pipe[`MSQ_F_FEN] & ~pipe[`MSQ_F_SDIR];
    assign hit = CYC_I & STB_I & ~q.ack;
    assign res_lo = RESULT_I[`MSQ_AW-1:0];
    assign dir_plus = pipe[`MSQ_F_DIR_MSB:`MSQ_F_DIR_LSB]
                      + {8'h00, pipe[`MSQ_F_INC]};
    assign merged = lane_merge((ADR_I == `MSQ_R_UADDR) ? {23'h000000, q.uaddr} : q.hold_lo,
                               DAT_I, SEL_I);
    assign mem_wdata = {DAT_I[7:0], q.hold_lo};

    always_comb
    begin
        case (src)
            msq_pkg::MSQ_SRC_PC: next_addr = q.upc;
            msq_pkg::MSQ_SRC_AR: next_addr = q.ar;
            msq_pkg::MSQ_SRC_STK: next_addr = q.stack[q.sp];
            msq_pkg::MSQ_SRC_DIR: next_addr = pipe[`MSQ_F_DIR_MSB:`MSQ_F_DIR_LSB];
            default: next_addr = q.upc;
        endcase
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        next_q = q;
        mem_we = 1'b0;
        next_q.pan_s = {q.pan_s[0], PANEL_CLEAR_I};
        next_q.host_s = {q.host_s[0], HOST_BUS_RESET_I};
        next_q.clr_req = 1'b0;
        next_q.ack = hit;
        next_q.ar = res_lo;
        if (clr)
        begin
            next_q.upc = '0;
        end
        else if (seq_go)
        begin
            // wraps at 511 like the nine-bit incrementer would
            next_q.upc = next_addr + {8'h00, pipe[`MSQ_F_INC]};
        end
        if (push)
        begin
            // pointer wraps; deeper nesting overwrites the oldest return
            next_q.sp = q.sp + 2'h1;
            next_q.stack[q.sp + 2'h1] = q.upc;
        end
        else if (pop)
        begin
            next_q.sp = q.sp - 2'h1;
        end
        if (pipe[`MSQ_F_OSEL])
        begin
            next_q.cbus = RESULT_I;
            next_q.cvld = 1'b1;
            next_q.yvld = 1'b0;
        end
        else
        begin
            next_q.ybus = RESULT_I;
            next_q.yvld = 1'b1;
            next_q.cvld = 1'b0;
        end
        if (hit)
        begin
            next_q.rdata = 32'h00000000;
            case (ADR_I)
                `MSQ_R_CTRL:
                begin
                    if (WE_I && SEL_I[0])
                    begin
                        next_q.run = DAT_I[`MSQ_CTRL_RUN];
                        next_q.clr_req = DAT_I[`MSQ_CTRL_CLR];
                    end
                    next_q.rdata = {31'h00000000, q.run};
                end
                `MSQ_R_STAT: next_q.rdata = {2'h0, q.ar, clr, q.sp, 9'h000, q.upc};
                `MSQ_R_UADDR:
                begin
                    if (WE_I)
                    begin
                        next_q.uaddr = merged[`MSQ_AW-1:0];
                    end
                    next_q.rdata = {23'h000000, q.uaddr};
                end
                `MSQ_R_UDLO:
                begin
                    if (WE_I)
                    begin
                        next_q.hold_lo = merged;
                    end
                    next_q.rdata = q.hold_lo;
                end
                `MSQ_R_UDHI:
                begin
                    // upper byte commits the word and steps the load address
                    if (WE_I && SEL_I[0])
                    begin
                        mem_we = 1'b1;
                        next_q.uaddr = q.uaddr + 9'h001;
                    end
                end
                `MSQ_R_PIPLO: next_q.rdata = pipe[31:0];
                `MSQ_R_PIPHI: next_q.rdata = {24'h000000, pipe[`MSQ_UW-1:32]};
                `MSQ_R_INREG: next_q.rdata = {16'h0000, inreg};
                default: next_q.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            q <= '0;
        end
        else
        begin
            q <= next_q;
        end
    end

    // ------------------------------------------------------------------
    // microprogram store
    // ------------------------------------------------------------------
    // fetch of the next word overlaps execution of the current one
    msq_ustore u_store (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .clr_i(clr),
        .we_i(mem_we),
        .waddr_i(q.uaddr),
        .wdata_i(mem_wdata),
        .re_i(seq_go),
        .raddr_i(next_addr),
        .dbus_i(D_BUS_I),
        .pipe_o(pipe),
        .inreg_o(inreg)
    );

    assign DAT_O = q.rdata;
    assign ACK_O = q.ack;
    assign MICROWORD_O = pipe;
    assign INPUT_REG_O = inreg;
    assign MPC_O = q.upc;
    assign Y_BUS_O = q.ybus;
    assign Y_BUS_VALID_O = q.yvld;
    assign C_BUS_O = q.cbus;
    assign C_BUS_VALID_O = q.cvld;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_upc_inc;
        @(posedge CLK_I) disable iff (RST_I)
        seq_go && src == msq_pkg::MSQ_SRC_PC && pipe[`MSQ_F_INC]
        |=> MPC_O == $past(MPC_O) + 9'h001;
    endproperty
    a_upc_inc: assert property (p_upc_inc) else $error("counter did not step");

    property p_upc_hold;
        @(posedge CLK_I) disable iff (RST_I)
        seq_go && src == msq_pkg::MSQ_SRC_PC && !pipe[`MSQ_F_INC] |=> $stable(MPC_O);
    endproperty
    a_upc_hold: assert property (p_upc_hold) else $error("repeat did not hold counter");

    property p_clear;
        @(posedge CLK_I) disable iff (RST_I)
        clr |=> MPC_O == 9'h000 && MICROWORD_O == 40'h0000000000;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not zero counter");

    property p_ar;
        @(posedge CLK_I) disable iff (RST_I)
        1'b1 |=> q.ar == $past(res_lo);
    endproperty
    a_ar: assert property (p_ar) else $error("address register missed result");

    property p_push;
        @(posedge CLK_I) disable iff (RST_I)
        push |=> q.sp == $past(q.sp) + 2'h1 && q.stack[q.sp] == $past(MPC_O);
    endproperty
    a_push: assert property (p_push) else $error("push failed");

    property p_pop;
        @(posedge CLK_I) disable iff (RST_I)
        pop |=> q.sp == $past(q.sp) - 2'h1;
    endproperty
    a_pop: assert property (p_pop) else $error("pop failed");

    property p_hold_stack;
        @(posedge CLK_I) disable iff (RST_I)
        pipe[`MSQ_F_FEN] || !seq_go |=> $stable(q.sp) && $stable(q.stack);
    endproperty
    a_hold_stack: assert property (p_hold_stack) else $error("stack changed");

    property p_wrap;
        @(posedge CLK_I) disable iff (RST_I)
        push && q.sp == 2'h3 |=> q.sp == 2'h0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("pointer did not wrap");

    property p_direct;
        @(posedge CLK_I) disable iff (RST_I)
        seq_go && src == msq_pkg::MSQ_SRC_DIR |=> MPC_O == $past(dir_plus);
    endproperty
    a_direct: assert property (p_direct) else $error("direct branch missed");

    property p_imm;
        @(posedge CLK_I) disable iff (RST_I)
        MICROWORD_O[`MSQ_F_LDI] |-> INPUT_REG_O == MICROWORD_O[`MSQ_F_IMM_MSB:0];
    endproperty
    a_imm: assert property (p_imm) else $error("constant not in input register");

    property p_ack;
        @(posedge CLK_I) disable iff (RST_I)
        hit |=> ACK_O ##1 !ACK_O;
    endproperty
    a_ack: assert property (p_ack) else $error("bus answer wrong");

endmodule

// file: rtl/msq_cfg.svh
// microprogram sequencer constants: widths, microword fields, register map
`ifndef MSQ_CFG_SVH
`define MSQ_CFG_SVH

// ----------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------
`define MSQ_AW 9
`define MSQ_DEPTH 512
`define MSQ_UW 40
`define MSQ_DW 16
`define MSQ_SDEPTH 4
`define MSQ_SPW 2

// ----------------------------------------------------------------------
// microword fields
// ----------------------------------------------------------------------
`define MSQ_F_IMM_LSB 0
`define MSQ_F_IMM_MSB 15
`define MSQ_F_DIR_LSB 0
`define MSQ_F_DIR_MSB 8
`define MSQ_F_SEL_LSB 16
`define MSQ_F_SEL_MSB 17
`define MSQ_F_FEN 18
`define MSQ_F_SDIR 19
`define MSQ_F_INC 20
`define MSQ_F_LDI 21
`define MSQ_F_OSEL 22

// ----------------------------------------------------------------------
// register map, byte addresses
// ----------------------------------------------------------------------
`define MSQ_R_CTRL 8'h00
`define MSQ_R_STAT 8'h04
`define MSQ_R_UADDR 8'h08
`define MSQ_R_UDLO 8'h0C
`define MSQ_R_UDHI 8'h10
`define MSQ_R_PIPLO 8'h14
`define MSQ_R_PIPHI 8'h18
`define MSQ_R_INREG 8'h1C
`define MSQ_CTRL_RUN 0
`define MSQ_CTRL_CLR 1

`endif

// file: rtl/msq_pkg.sv
// microprogram sequencer types
`include "msq_cfg.svh"
package msq_pkg;

    typedef enum logic [1:0] {
        MSQ_SRC_PC = 2'h0,
        MSQ_SRC_AR = 2'h1,
        MSQ_SRC_STK = 2'h2,
        MSQ_SRC_DIR = 2'h3
    } msq_src_t;

    typedef struct packed {
        logic [`MSQ_AW-1:0] upc;
        logic [`MSQ_AW-1:0] ar;
        logic [`MSQ_SPW-1:0] sp;
        logic [`MSQ_SDEPTH-1:0][`MSQ_AW-1:0] stack;
        logic [1:0] pan_s;
        logic [1:0] host_s;
        logic run;
        logic clr_req;
        logic [`MSQ_AW-1:0] uaddr;
        logic [31:0] hold_lo;
        logic ack;
        logic [31:0] rdata;
        logic [`MSQ_DW-1:0] ybus;
        logic yvld;
        logic [`MSQ_DW-1:0] cbus;
        logic cvld;
    } msq_state_t;

    typedef struct packed {
        logic [`MSQ_UW-1:0] pipe;
        logic [`MSQ_DW-1:0] inreg;
    } msq_store_t;

endpackage

// file: rtl/msq_ustore.sv
// microprogram memory with pipeline register and datapath input register
`timescale 1ns/1ps
`include "msq_cfg.svh"
module msq_ustore (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clr_i,
    input wire logic we_i,
    input wire logic [`MSQ_AW-1:0] waddr_i,
    input wire logic [`MSQ_UW-1:0] wdata_i,
    input wire logic re_i,
    input wire logic [`MSQ_AW-1:0] raddr_i,
    input wire logic [`MSQ_DW-1:0] dbus_i,
    output logic [`MSQ_UW-1:0] pipe_o,
    output logic [`MSQ_DW-1:0] inreg_o
);

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [`MSQ_UW-1:0] mem [0:`MSQ_DEPTH-1];
    logic [`MSQ_UW-1:0] word;
    msq_pkg::msq_store_t q, next_q;

    assign word = mem[raddr_i];

    always_ff @(posedge clk_i)
    begin
        if (we_i)
        begin
            mem[waddr_i] <= wdata_i;
        end
    end

    // ------------------------------------------------------------------
    // pipeline and input register, loaded on the same edge
    // ------------------------------------------------------------------
    always_comb
    begin
        next_q = q;
        if (clr_i)
        begin
            next_q.pipe = '0;
        end
        else if (re_i)
        begin
            next_q.pipe = word;
            // immediate rides with its own microword
            if (word[`MSQ_F_LDI])
            begin
                next_q.inreg = word[`MSQ_F_IMM_MSB:`MSQ_F_IMM_LSB];
            end
            else
            begin
                next_q.inreg = dbus_i;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q <= '0;
        end
        else
        begin
            q <= next_q;
        end
    end

    assign pipe_o = q.pipe;
    assign inreg_o = q.inreg;

endmodule

// file: tb/msq_dp_model.sv
// datapath partner model: drives the result bus and the external input bus
`timescale 1ns/1ps
module msq_dp_model #(
    parameter logic [8:0] JUMP = 9'h030,
    parameter logic [15:0] DIN = 16'h5A0F
) (
    output logic [15:0] result_o,
    output logic [15:0] d_bus_o
);
    // ----------------------------------------------------------------------
    // buses
    // ----------------------------------------------------------------------
    // low nine result bits steer computed jumps
    assign result_o = {7'h15, JUMP};
    // operand source when no constant is loaded
    assign d_bus_o = DIN;
endmodule

// file: tb/tb_top.sv
// testbench: wishbone tasks, microprogram load and sequencer traces
`timescale 1ns/1ps
`include "msq_cfg.svh"
module tb_top;
    logic clk, rst, cyc, stb, we, ack, pclr, hrst, yv, cv;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat, dout, r;
    logic [15:0] res, dbus, inreg, ybus, cbus;
    logic [39:0] mw, w_seq, w_jsr, w_jar, w_ldi, w_rtn, w_rep, w_end;
    logic [39:0] ew [6];
    logic [8:0] mpc, pc;
    logic [8:0] ep [6];
    int mismatches, tests_run;

    msq_top dut (.CLK_I(clk), .RST_I(rst), .ADR_I(adr), .DAT_I(dat), .WE_I(we),
        .SEL_I(sel), .CYC_I(cyc), .STB_I(stb), .DAT_O(dout), .ACK_O(ack),
        .PANEL_CLEAR_I(pclr), .HOST_BUS_RESET_I(hrst), .RESULT_I(res), .D_BUS_I(dbus),
        .MICROWORD_O(mw), .INPUT_REG_O(inreg), .MPC_O(mpc), .Y_BUS_O(ybus),
        .Y_BUS_VALID_O(yv), .C_BUS_O(cbus), .C_BUS_VALID_O(cv));
    msq_dp_model partner (.result_o(res), .d_bus_o(dbus));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ----------------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------------
    function automatic logic [39:0] uw(input logic [1:0] s, input logic [4:0] f,
        input logic [15:0] imm, input logic [16:0] tag);
        logic [39:0] w;
        w = {tag, 2'h0, 5'h00, imm};
        w[`MSQ_F_SEL_MSB:`MSQ_F_SEL_LSB] = s;
        w[`MSQ_F_OSEL:`MSQ_F_FEN] = f;
        return w;
    endfunction

    task automatic check(input logic [39:0] got, input logic [39:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    // classic cycle held until ack is sampled high at an edge
    task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic w);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        adr <= a;
        dat <= d;
        we <= w;
        sel <= 4'hF;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        if (n >= 50)
            check(1'b0, 1'b1, "bus ack");
        r = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask

    task automatic ld(input logic [8:0] a, input logic [39:0] w);
        wb(`MSQ_R_UADDR, {23'h0, a}, 1'b1);
        wb(`MSQ_R_UDLO, w[31:0], 1'b1);
        wb(`MSQ_R_UDHI, {24'h0, w[39:32]}, 1'b1);
    endtask

    // waits for the call word, then follows call, constant, return, computed jump
    task automatic trace();
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while (mw !== w_jsr && n < 100);
        check(mpc, 9'h009, "upc at call");
        for (int k = 0; k < 6; k++)
        begin
            @(posedge clk);
            #1;
            check(mw, ew[k], "microword");
            check(mpc, ep[k], "upc");
            if (k == 0)
                check(inreg, 16'hA5C3, "constant");
            if (k == 0)
                check({cv, yv, ybus}, {2'h1, 7'h15, 9'h030}, "result bus");
            if (k == 1)
                check(inreg, 16'h5A0F, "input bus");
        end
        check({cv, yv, cbus}, {2'h2, 7'h15, 9'h030}, "secondary bus");
        $display("test trace done at %0t", $time);
        @(posedge clk);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        #400000;
        mismatches++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        give_verdict();
    end

    // ----------------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------------
    initial
    begin
        {rst, cyc, stb, we, pclr, hrst} = 6'h20;
        {adr, dat, sel} = '0;
        // fields: f = {osel, ldi, inc, dir, fen_n}
        w_seq = uw(2'h0, 5'h05, 16'h0000, 17'h00011);
        w_jsr = uw(2'h3, 5'h06, 16'h0020, 17'h00022);
        w_jar = uw(2'h1, 5'h05, 16'h0000, 17'h00033);
        w_ldi = uw(2'h0, 5'h0D, 16'hA5C3, 17'h00044);
        w_rtn = uw(2'h2, 5'h04, 16'h0000, 17'h00055);
        w_rep = uw(2'h0, 5'h01, 16'h0000, 17'h00066);
        w_end = uw(2'h0, 5'h11, 16'h0000, 17'h00077);
        ew = '{w_ldi, w_rtn, w_jar, w_rep, w_end, w_end};
        ep = '{9'h021, 9'h022, 9'h00A, 9'h031, 9'h031, 9'h031};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        wb(`MSQ_R_CTRL, 32'h0, 1'b0);
        check(r, 32'h0, "ctrl after reset");
        for (int i = 0; i < 8; i++)
            ld(9'(i), w_seq);
        ld(9'h008, w_jsr);
        ld(9'h009, w_jar);
        ld(9'h020, w_ldi);
        ld(9'h021, w_rtn);
        ld(9'h030, w_rep);
        ld(9'h031, w_end);
        wb(`MSQ_R_CTRL, 32'h1, 1'b1);
        trace();
        // panel switch, host reset line, then software clear pulse
        for (int m = 0; m < 3; m++)
        begin
            if (m == 2)
                wb(`MSQ_R_CTRL, 32'h3, 1'b1);
            else
            begin
                pclr <= (m == 0);
                hrst <= (m == 1);
                repeat (6) @(posedge clk);
                check(mpc, 9'h000, "clear");
                pclr <= 1'b0;
                hrst <= 1'b0;
            end
            trace();
        end
        // restart from zero and halt one step later; a running counter would move on
        wb(`MSQ_R_CTRL, 32'h3, 1'b1);
        wb(`MSQ_R_CTRL, 32'h0, 1'b1);
        pc = mpc;
        check(pc, 9'h001, "halt point");
        repeat (4) @(posedge clk);
        check(mpc, pc, "halt hold");
        wb(`MSQ_R_STAT, 32'h0, 1'b0);
        check(r[8:0], pc, "status upc");
        check(r[29:21], 9'h030, "status address register");
        wb(`MSQ_R_PIPLO, 32'h0, 1'b0);
        check(r, w_seq[31:0], "pipeline low");
        wb(`MSQ_R_PIPHI, 32'h0, 1'b0);
        check(r, {24'h0, w_seq[39:32]}, "pipeline high");
        wb(`MSQ_R_INREG, 32'h0, 1'b0);
        check(r, {16'h0, 16'h5A0F}, "input register");
        wb(8'hFC, 32'h0, 1'b0);
        check(r, 32'h0, "unmapped read");
        $display("test registers done at %0t", $time);
        give_verdict();
    end
endmodule
